// ### src/nvc_top.sv
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "nvc_defs.svh"
module nvc_top (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output      logic [31:0]          wb_dat_o,
   output      logic                 wb_ack_o,
   // Requester identity and debug port key
   input  wire logic                 requester_ext_i,
   input  wire logic                 key_valid_i,
   // Memory array side
   output      logic                 mem_req_o,
   output      nvc_pkg::nvc_mem_op_t mem_op_o,
   input  wire logic                 mem_done_i,
   input  wire logic [15:0]          mem_rdata_i,
   // Status outputs
   output      logic                 busy_o,
   output      logic                 app_read_block_o,
   output      logic                 mem_if_enable_o,
   output      logic [23:0]          reset_vec_o,
   output      logic                 irq_o
);

   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   nvc_pkg::nvc_state_t state_q;       // Controller state
   nvc_pkg::nvc_cmd_t   cmd_q;         // Selected command
   logic [23:0]         addr_q;        // Memory address
   logic [15:0]         data_q;        // Memory data
   logic                autoinc_q;     // Address step after access
   logic [7:0]          lock_q;        // Lock settings
   logic                fuse_boot_q;   // Reset vector fuse
   logic                memen_q;       // Programming port enabled
   logic [1:0]          int_st_q;      // Sticky event flags
   logic [1:0]          int_msk_q;     // Event mask
   logic [3:0]          ccp_cnt_q;     // Unlock window counter
   logic                busy_q;        // Busy flag
   logic                req;           // New bus request
   logic                wr_acc;        // Bus write this cycle
   logic                rd_acc;        // Bus read this cycle
   logic                trig_act;      // Action trigger
   logic                trig_rd;       // Read trigger
   logic                trig_wr;       // Write trigger
   logic                trig;          // Any trigger
   logic [15:0]         op_wdata;      // Data for the new operation
   logic                permit;        // Privilege check result
   logic                ccp_ok;        // Unlock satisfied
   logic                start;         // Operation accepted
   logic                deny_evt;      // Trigger refused
   logic                done_evt;      // Operation completed
   logic                reg_wr_ok;     // Register writes allowed
   logic [31:0]         rd_mux;        // Register read data
   logic [31:0]         wmerge;        // Byte-lane merged write data
   logic [31:0]         addr_mrg;      // Address merged with written lanes
   logic [31:0]         data_mrg;      // Data merged with written lanes

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Merge written byte lanes into an old value
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Privilege check per requester, space and lock setting
   function automatic logic access_ok(
      input nvc_pkg::nvc_cmd_t c,
      input logic              ext,
      input logic              en,
      input logic [23:0]       a,
      input logic [15:0]       wd,
      input logic [7:0]        lk);
      logic r;
      r = 1'b0;
      if (ext) begin
         // Programmer, once enabled: flash per lock bits, no production row writes or SP_NONE, all else allowed
         case (c.space)
            nvc_pkg::SP_FLASH: r = c.wr ? lk[`NVC_LK_EXT_WR]
                                        : lk[`NVC_LK_EXT_RD];
            nvc_pkg::SP_PSIG:  r = ~c.wr;
            nvc_pkg::SP_NONE:  r = 1'b0;
            default:           r = 1'b1;
         endcase
         r = r & en;
      end else begin
         // On-chip software
         case (c.space)
            nvc_pkg::SP_FLASH: begin
               if (!c.wr) begin
                  r = 1'b1;
               end else if (a >= `NVC_BOOT_START) begin
                  r = lk[`NVC_LK_BOOT_WR];
               end else if (a >= `NVC_TBL_START) begin
                  r = lk[`NVC_LK_TBL_WR];
               end else begin
                  r = lk[`NVC_LK_APP_WR];
               end
            end
            nvc_pkg::SP_EEPROM,
            nvc_pkg::SP_USIG:  r = 1'b1;
            nvc_pkg::SP_PSIG,
            nvc_pkg::SP_FUSE:  r = ~c.wr;
            nvc_pkg::SP_LOCK:  r = c.wr & ((wd[7:0] & ~lk) == 8'h00);
            nvc_pkg::SP_CRC:   r = 1'b1;
            default:           r = 1'b0;
         endcase
      end
      return r;
   endfunction

   //------------------------------------------------------------
   // Request decode and triggers
   //------------------------------------------------------------
   assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o &
                   (state_q != nvc_pkg::ST_RDWAIT);
   assign wr_acc = req & wb_we_i;
   assign rd_acc = req & ~wb_we_i;
   assign wmerge = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   assign addr_mrg = lane_merge({8'h00, addr_q}, wb_dat_i, wb_sel_i);
   assign data_mrg = lane_merge({16'h0000, data_q}, wb_dat_i, wb_sel_i);

   // Execute bit starts checksum commands
   assign trig_act = wr_acc & (wb_adr_i == `NVC_OFF_CONTROL_REGISTER_A) &
                     wmerge[`NVC_EXEC_BIT] &
                     (cmd_q.space == nvc_pkg::SP_CRC);
   // Window read starts read commands
   assign trig_rd  = rd_acc & (wb_adr_i == `NVC_OFF_WIN) & ~cmd_q.wr &
                     (cmd_q.space != nvc_pkg::SP_CRC);
   // Window write starts write commands
   assign trig_wr  = wr_acc & (wb_adr_i == `NVC_OFF_WIN) & cmd_q.wr &
                     (cmd_q.space != nvc_pkg::SP_CRC);
   assign trig     = trig_act | trig_rd | trig_wr;
   assign op_wdata = trig_wr ? wb_dat_i[15:0] : data_q;

   // All spaces funnel through this single check and start
   assign permit   = access_ok(cmd_q, requester_ext_i, memen_q,
                               addr_q, op_wdata, lock_q);
   // Software action and write triggers need an open unlock window
   assign ccp_ok   = requester_ext_i | trig_rd | (ccp_cnt_q != 4'h0);
   // Any running operation refuses new triggers
   assign start    = trig & permit & ccp_ok & ~busy_q;
   assign deny_evt = trig & ~start;
   assign done_evt = mem_done_i & busy_q;
   assign reg_wr_ok = wr_acc & ~busy_q;

   //------------------------------------------------------------
   // Controller state
   //------------------------------------------------------------
   // Idle, running, or running with a bus read waiting on it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= nvc_pkg::ST_IDLE;
      end else begin
         case (state_q)
            nvc_pkg::ST_IDLE: begin
               if (start && trig_rd) begin
                  state_q <= nvc_pkg::ST_RDWAIT;
               end else if (start) begin
                  state_q <= nvc_pkg::ST_BUSY;
               end
            end
            nvc_pkg::ST_BUSY,
            nvc_pkg::ST_RDWAIT: begin
               if (mem_done_i) begin
                  state_q <= nvc_pkg::ST_IDLE;
               end
            end
            default: state_q <= nvc_pkg::ST_IDLE;
         endcase
      end
   end

   // Busy flag and programming read block
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q           <= 1'b0;
         app_read_block_o <= 1'b0;
      end else if (start) begin
         busy_q           <= 1'b1;
         // Every window-triggered write, in any space, stalls the application section;
         // boot code keeps fetching meanwhile
         app_read_block_o <= trig_wr;
      end else if (done_evt) begin
         busy_q           <= 1'b0;
         app_read_block_o <= 1'b0;
      end
   end
   assign busy_o = busy_q;

   // Operation handed to the memory array
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_req_o <= 1'b0;
         mem_op_o  <= '0;
      end else begin
         mem_req_o <= start;
         if (start) begin
            mem_op_o.cmd   <= cmd_q;
            mem_op_o.addr  <= addr_q;
            mem_op_o.wdata <= op_wdata;
         end
      end
   end

   //------------------------------------------------------------
   // Software registers
   //------------------------------------------------------------
   // Command, control B and address; frozen while busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q     <= nvc_pkg::nvc_cmd_t'(`NVC_CMD_RST);
         autoinc_q <= 1'b0;
         addr_q    <= 24'h00_0000;
      end else begin
         if (reg_wr_ok && wb_adr_i == `NVC_OFF_CMD && wb_sel_i[0]) begin
            cmd_q <= nvc_pkg::nvc_cmd_t'(wb_dat_i[3:0]);
         end
         if (reg_wr_ok && wb_adr_i == `NVC_OFF_CTRLB && wb_sel_i[0]) begin
            autoinc_q <= wb_dat_i[`NVC_AUTOINC_BIT];
         end
         if (reg_wr_ok && wb_adr_i == `NVC_OFF_ADDR) begin
            addr_q <= addr_mrg[23:0];
         end else if (done_evt && autoinc_q &&
                      mem_op_o.cmd.space != nvc_pkg::SP_CRC) begin
            addr_q <= addr_q + 24'h00_0001;
         end
      end
   end

   // Data register: written by software, loaded by reads and checksums
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_q <= 16'h0000;
      end else if (done_evt && !mem_op_o.cmd.wr) begin
         data_q <= mem_rdata_i;
      end else if (done_evt && mem_op_o.cmd.space == nvc_pkg::SP_CRC) begin
         data_q <= mem_rdata_i;
      end else if (reg_wr_ok && (wb_adr_i == `NVC_OFF_DATA ||
                                 wb_adr_i == `NVC_OFF_WIN)) begin
         data_q <= data_mrg[15:0];
      end
   end

   // Lock and fuse settings, changed only by completed writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q      <= `NVC_LOCK_RST;
         fuse_boot_q <= 1'b0;
      end else if (done_evt && mem_op_o.cmd.wr) begin
         if (mem_op_o.cmd.space == nvc_pkg::SP_LOCK) begin
            lock_q <= mem_op_o.wdata[7:0];
         end
         if (mem_op_o.cmd.space == nvc_pkg::SP_FUSE) begin
            fuse_boot_q <= mem_op_o.wdata[0];
         end
      end
   end

   // Reset vector from the fuse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_vec_o <= `NVC_APP_START;
      end else begin
         reset_vec_o <= fuse_boot_q ? `NVC_BOOT_START
                                    : `NVC_APP_START;
      end
   end

   // Unlock window: opened by the key, closed by use or timeout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ccp_cnt_q <= 4'h0;
      end else if (wr_acc && wb_adr_i == `NVC_OFF_CCP && wb_sel_i[0] &&
                   wb_dat_i[7:0] == `NVC_CCP_KEY) begin
         ccp_cnt_q <= `NVC_CCP_WIN;
      end else if (start) begin
         ccp_cnt_q <= 4'h0;
      end else if (ccp_cnt_q != 4'h0) begin
         ccp_cnt_q <= ccp_cnt_q - 4'h1;
      end
   end

   // Programming port enable: key sets, a write of one clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         memen_q <= 1'b0;
      end else if (key_valid_i) begin
         memen_q <= 1'b1;
      end else if (wr_acc && wb_adr_i == `NVC_OFF_MEMEN &&
                   wb_sel_i[0] && wb_dat_i[`NVC_MEMEN_BIT]) begin
         memen_q <= 1'b0;
      end
   end
   assign mem_if_enable_o = memen_q;

   //------------------------------------------------------------
   // Interrupts
   //------------------------------------------------------------
   // Sticky flags, write one to clear, new events win
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_st_q  <= 2'b00;
         int_msk_q <= 2'b00;
      end else begin
         int_st_q <= (int_st_q &
                      ~((wr_acc && wb_adr_i == `NVC_OFF_INTST &&
                         wb_sel_i[0]) ? wb_dat_i[1:0] : 2'b00)) |
                     {deny_evt, done_evt};
         if (wr_acc && wb_adr_i == `NVC_OFF_INTMSK && wb_sel_i[0]) begin
            int_msk_q <= wb_dat_i[1:0];
         end
      end
   end

   // Level interrupt output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(int_st_q & int_msk_q);
      end
   end

   //------------------------------------------------------------
   // Bus answer
   //------------------------------------------------------------
   // Register read multiplexer; unmapped reads return zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         `NVC_OFF_CMD:    rd_mux = {28'h000_0000, cmd_q};
         `NVC_OFF_CTRLB:  rd_mux = {31'h0000_0000, autoinc_q};
         `NVC_OFF_ADDR:   rd_mux = {8'h00, addr_q};
         `NVC_OFF_DATA:   rd_mux = {16'h0000, data_q};
         `NVC_OFF_STATUS: rd_mux = {30'h0000_0000, memen_q, busy_q};
         `NVC_OFF_INTST:  rd_mux = {30'h0000_0000, int_st_q};
         `NVC_OFF_INTMSK: rd_mux = {30'h0000_0000, int_msk_q};
         `NVC_OFF_CCP:    rd_mux = {31'h0000_0000, ccp_cnt_q != 4'h0};
         `NVC_OFF_LOCK:   rd_mux = {24'h00_0000, lock_q};
         `NVC_OFF_FUSE:   rd_mux = {31'h0000_0000, fuse_boot_q};
         `NVC_OFF_MEMEN:  rd_mux = {30'h0000_0000, memen_q, 1'b0};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Ack next cycle, except started memory reads wait for the array
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (state_q == nvc_pkg::ST_RDWAIT) begin
         wb_ack_o <= mem_done_i;
         wb_dat_o <= {16'h0000, mem_rdata_i};
      end else begin
         wb_ack_o <= req & ~(start & trig_rd);
         wb_dat_o <= rd_acc ? rd_mux : 32'h0000_0000;
      end
   end

endmodule // nvc_top

// ### src/nvc_defs.svh
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH
// Register byte offsets
`define NVC_OFF_CMD     8'h00
`define NVC_OFF_CONTROL_REGISTER_A   8'h04
`define NVC_OFF_CTRLB   8'h08
`define NVC_OFF_ADDR    8'h0C
`define NVC_OFF_DATA    8'h10
`define NVC_OFF_STATUS  8'h14
`define NVC_OFF_INTST   8'h18
`define NVC_OFF_INTMSK  8'h1C
`define NVC_OFF_CCP     8'h20
`define NVC_OFF_LOCK    8'h24
`define NVC_OFF_FUSE    8'h28
`define NVC_OFF_MEMEN   8'h2C
`define NVC_OFF_WIN     8'h30
// Field positions
`define NVC_EXEC_BIT    0
`define NVC_AUTOINC_BIT 0
`define NVC_MEMEN_BIT   1
`define NVC_INT_DONE    0
`define NVC_INT_DENY    1
// Lock bit positions (1 = access allowed)
`define NVC_LK_EXT_WR   0
`define NVC_LK_EXT_RD   1
`define NVC_LK_BOOT_WR  2
`define NVC_LK_APP_WR   3
`define NVC_LK_TBL_WR   4
// Reset values
`define NVC_LOCK_RST    8'hFF
`define NVC_CMD_RST     4'h0
// Unlock key and window length in cycles
`define NVC_CCP_KEY     8'hA5
`define NVC_CCP_WIN     4'h8
// Flash section boundaries (word address)
`define NVC_TBL_START   24'h00E000
`define NVC_BOOT_START  24'h010000
`define NVC_APP_START   24'h000000
`endif

// ### src/nvc_pkg.sv
package nvc_pkg;
   // Memory space selected by a command
   typedef enum logic [2:0] {
      SP_FLASH  = 3'h0,
      SP_EEPROM = 3'h1,
      SP_USIG   = 3'h2,
      SP_PSIG   = 3'h3,
      SP_FUSE   = 3'h4,
      SP_LOCK   = 3'h5,
      SP_CRC    = 3'h6,
      SP_NONE   = 3'h7
   } nvc_space_t;
   // Command code: space plus write flag (CRC: 1 = section)
   typedef struct packed {
      nvc_space_t space;
      logic       wr;
   } nvc_cmd_t;
   // Operation handed to the memory array
   typedef struct packed {
      nvc_cmd_t    cmd;
      logic [23:0] addr;
      logic [15:0] wdata;
   } nvc_mem_op_t;
   // Controller states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_BUSY   = 3'b010,
      ST_RDWAIT = 3'b100
   } nvc_state_t;
endpackage

// ### dv/nvc_top_sva.sv
`timescale 1ns/10ps
`include "nvc_defs.svh"
module nvc_top_sva (
   // Clock and reset
   input logic                 clk_i,
   input logic                 rst_i,
   // Wishbone slave
   input logic                 wb_cyc_i,
   input logic                 wb_stb_i,
   input logic                 wb_we_i,
   input logic [7:0]           wb_adr_i,
   input logic [3:0]           wb_sel_i,
   input logic [31:0]          wb_dat_i,
   input logic [31:0]          wb_dat_o,
   input logic                 wb_ack_o,
   // Requester and key
   input logic                 requester_ext_i,
   input logic                 key_valid_i,
   // Memory array side
   input logic                 mem_req_o,
   input nvc_pkg::nvc_mem_op_t mem_op_o,
   input logic                 mem_done_i,
   input logic [15:0]          mem_rdata_i,
   // Status
   input logic                 busy_o,
   input logic                 app_read_block_o,
   input logic                 mem_if_enable_o,
   input logic [23:0]          reset_vec_o,
   input logic                 irq_o
);
   // ----------------------------------------
   // Checks on the outputs
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   req_busy_a: assert property (mem_req_o |-> busy_o)
      else $error("start without busy");
   busy_hold_a: assert property (busy_o && !mem_done_i |=> busy_o)
      else $error("busy dropped before completion");
   done_free_a: assert property (busy_o && mem_done_i |=> !busy_o)
      else $error("busy kept after completion");
   no_overlap_a: assert property (mem_req_o |-> !$past(busy_o))
      else $error("start while busy");
   op_hold_a: assert property (!mem_req_o && !$past(rst_i)
      |-> $stable(mem_op_o)) else $error("operation changed");
   blk_busy_a: assert property (app_read_block_o |-> busy_o)
      else $error("read block while idle");
   win_read_a: assert property (busy_o && mem_done_i && wb_cyc_i
      && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `NVC_OFF_WIN
      |=> wb_ack_o && wb_dat_o[15:0] == $past(mem_rdata_i))
      else $error("window read answer wrong");
   key_en_a: assert property (key_valid_i |=> mem_if_enable_o)
      else $error("key did not enable");
   vec_sel_a: assert property (reset_vec_o == `NVC_APP_START
      || reset_vec_o == `NVC_BOOT_START) else $error("bad reset vector");
endmodule // nvc_top_sva
bind nvc_top nvc_top_sva u_sva (.*);

// ### dv/nvc_mem_model.sv
`timescale 1ns/10ps
module nvc_mem_model (
   // Clock and reset
   input  logic                 clk_i,
   input  logic                 rst_i,
   // Operation from the controller
   input  logic                 mem_req_o,
   input  nvc_pkg::nvc_mem_op_t mem_op_o,
   input  int                   lat_i,
   // Answer to the controller
   output logic                 mem_done_i,
   output logic [15:0]          mem_rdata_i
);
   int cnt_q; // Cycles left in the running operation
   // Finishes each operation after lat_i cycles
   always_ff @(posedge clk_i) begin
      mem_done_i <= 1'b0;
      mem_rdata_i <= ~mem_rdata_i; // Data not valid: flips every cycle
      if (rst_i) begin
         cnt_q <= 0;
         mem_rdata_i <= 16'h0000;
      end else if (mem_req_o) begin
         cnt_q <= lat_i;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
         if (cnt_q == 1) begin
            mem_done_i <= 1'b1;
            mem_rdata_i <= mem_op_o.addr[15:0] ^ 16'hC3C3;
         end
      end
   end
endmodule // nvc_mem_model

// ### dv/test_nvc_top.sv
`timescale 1ns/10ps
`include "nvc_defs.svh"
`define CHK(g, e) begin #1; n_compared++; \
   if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module test_nvc_top;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic                 requester_ext_i = 1, key_valid_i = 0;
   logic [7:0]           wb_adr_i = 8'h00;
   logic [3:0]           wb_sel_i = 4'h0;
   logic [31:0]          wb_dat_i = 32'h0, wb_dat_o, rv;
   logic                 wb_ack_o, mem_req_o, mem_done_i, busy_o, irq_o;
   logic                 app_read_block_o, mem_if_enable_o;
   logic [15:0]          mem_rdata_i;
   logic [23:0]          reset_vec_o;
   nvc_pkg::nvc_mem_op_t mem_op_o;
   int lat = 1, n_req = 0, num_errors = 0, n_compared = 0, cyc_n = 0;
   nvc_top u_dut (.*);
   nvc_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_req_o(mem_req_o),
      .mem_op_o(mem_op_o), .lat_i(lat), .mem_done_i(mem_done_i),
      .mem_rdata_i(mem_rdata_i));
   always #5 clk_i = ~clk_i;
   // Counts starts and cuts a hang short
   always @(posedge clk_i) begin
      if (mem_req_o === 1'b1) n_req++;
      cyc_n++;
      if (cyc_n == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   // One classic Wishbone cycle, read data lands in rv
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rv = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   // Sets up a command, fires its trigger, expects e starts
   task run(input logic [3:0] c, input logic [31:0] d, input logic [1:0] k,
            input logic p, input int e);
      int r;
      bus(1'b1, `NVC_OFF_CMD, {28'h0, c});
      bus(1'b1, `NVC_OFF_ADDR, 32'h10);
      bus(1'b1, `NVC_OFF_DATA, d);
      if (p) bus(1'b1, `NVC_OFF_CCP, 32'hA5);
      r = n_req;
      if (k == 2'h0) bus(1'b1, `NVC_OFF_WIN, d);
      else if (k == 2'h1) bus(1'b0, `NVC_OFF_WIN, 32'h0);
      else bus(1'b1, `NVC_OFF_CONTROL_REGISTER_A, 32'h1);
      while (busy_o !== 1'b0) @(posedge clk_i);
      `CHK(n_req - r, e)
   endtask
   task t_reset;
      bus(1'b0, `NVC_OFF_STATUS, 32'h0); `CHK(rv, 32'h0)
      bus(1'b0, `NVC_OFF_LOCK, 32'h0); `CHK(rv, 32'hFF)
      bus(1'b0, `NVC_OFF_CMD, 32'h0); `CHK(rv, 32'h0)
      bus(1'b0, 8'h3C, 32'h0); `CHK(rv, 32'h0)
      `CHK(reset_vec_o, `NVC_APP_START)
      $display("t_reset end");
   endtask
   task t_ext;
      run(4'h0, 32'h0, 2'h1, 1'b0, 0); `CHK(rv, 32'h0)
      @(posedge clk_i) key_valid_i <= 1'b1;
      @(posedge clk_i) key_valid_i <= 1'b0;
      bus(1'b0, `NVC_OFF_STATUS, 32'h0); `CHK(rv, 32'h2)
      run(4'h0, 32'h0, 2'h1, 1'b0, 1); `CHK(rv, 32'hC3D3)
      `CHK(mem_op_o.addr, 24'h000010)
      bus(1'b0, `NVC_OFF_DATA, 32'h0); `CHK(rv, 32'hC3D3)
      run(4'h7, 32'h1, 2'h0, 1'b0, 0);
      run(4'h6, 32'h0, 2'h1, 1'b0, 1);
      $display("t_ext end");
   endtask
   task t_busy;
      int r;
      lat <= 20;
      bus(1'b1, `NVC_OFF_INTST, 32'h3);
      bus(1'b1, `NVC_OFF_CMD, 32'h3);
      bus(1'b1, `NVC_OFF_ADDR, 32'h10);
      bus(1'b1, `NVC_OFF_DATA, 32'hBEEF);
      r = n_req;
      bus(1'b1, `NVC_OFF_WIN, 32'hBEEF);
      `CHK(busy_o, 1'b1)
      `CHK(app_read_block_o, 1'b1)
      `CHK(mem_op_o.wdata, 16'hBEEF)
      bus(1'b1, `NVC_OFF_ADDR, 32'h77);
      bus(1'b1, `NVC_OFF_WIN, 32'h1234);
      while (busy_o !== 1'b0) @(posedge clk_i);
      `CHK(n_req - r, 1)
      bus(1'b0, `NVC_OFF_ADDR, 32'h0); `CHK(rv, 32'h10)
      bus(1'b0, `NVC_OFF_INTST, 32'h0); `CHK(rv, 32'h3)
      bus(1'b1, `NVC_OFF_INTMSK, 32'h1); `CHK(irq_o, 1'b1)
      bus(1'b1, `NVC_OFF_INTST, 32'h3); `CHK(irq_o, 1'b0)
      lat <= 1;
      $display("t_busy end");
   endtask
   task t_sw;
      bus(1'b1, `NVC_OFF_INTMSK, 32'h0);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      @(posedge clk_i) requester_ext_i <= 1'b0;
      run(4'h1, 32'h5, 2'h0, 1'b0, 0);
      run(4'h1, 32'h5, 2'h0, 1'b1, 1);
      run(4'h9, 32'h1, 2'h0, 1'b1, 0);
      run(4'h6, 32'h0, 2'h1, 1'b0, 1);
      run(4'hC, 32'h0, 2'h2, 1'b1, 1);
      `CHK(mem_op_o.cmd.space, nvc_pkg::SP_CRC)
      run(4'hD, 32'h0, 2'h2, 1'b1, 1);
      run(4'hB, 32'hF7, 2'h0, 1'b1, 1);
      bus(1'b0, `NVC_OFF_LOCK, 32'h0); `CHK(rv, 32'hF7)
      run(4'hB, 32'hFF, 2'h0, 1'b1, 0);
      run(4'h1, 32'h5, 2'h0, 1'b1, 0);
      $display("t_sw end");
   endtask
   task t_fuse;
      @(posedge clk_i) requester_ext_i <= 1'b1;
      run(4'h9, 32'h1, 2'h0, 1'b0, 1);
      repeat (2) @(posedge clk_i);
      `CHK(reset_vec_o, `NVC_BOOT_START)
      bus(1'b1, `NVC_OFF_MEMEN, 32'h2);
      bus(1'b0, `NVC_OFF_STATUS, 32'h0); `CHK(rv, 32'h0)
      run(4'h1, 32'h5, 2'h0, 1'b0, 0);
      $display("t_fuse end");
   endtask
   task give_verdict;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_ext();
      t_busy();
      t_sw();
      t_fuse();
      give_verdict();
   end
endmodule // test_nvc_top
